// ===== hw/mfr_regs.svh
`ifndef MFR_REGS_SVH
`define MFR_REGS_SVH

// ==========================================================================
// register offsets (byte addresses, one word each)
`define MFR_ADDR_W 12
`define MFR_CTRL_OFS 12'h000
`define MFR_RETRY_OFS 12'h004
`define MFR_IRQ_STS_OFS 12'h008
`define MFR_IRQ_MSK_OFS 12'h00C
`define MFR_FLT_OFS 12'h010

// ==========================================================================
// control register fields
`define MFR_CTRL_SEL_LSB 0
`define MFR_CTRL_SEL_MSB 3
`define MFR_CTRL_TMO_EN 4
`define MFR_CTRL_THERMAL_WARNING_REPORT_EN 5
`define MFR_CTRL_MEAS 6
`define MFR_CTRL_RES 7
`define MFR_CTRL_IND 8
`define MFR_CTRL_KE 9
`define MFR_CTRL_CLR 31
`define MFR_SEL_RST 4'h0
`define MFR_RETRY_W 24
`define MFR_RETRY_RST 24'h000064

// ==========================================================================
// fault flag positions (interrupt registers share only the low nine flags, not the fault-only fields)
`define MFR_EV_W 9
`define MFR_FL_LOCK 0
`define MFR_FL_RAMPUP 1
`define MFR_FL_RAMPDN 2
`define MFR_FL_RATE 3
`define MFR_FL_MPOS 4
`define MFR_FL_MBEMF 5
`define MFR_FL_OTW 6
`define MFR_FL_TSD 7
`define MFR_FL_CPUV 8
`define MFR_FLT_CTRL 9
`define MFR_FLT_DRV 10
`define MFR_FLT_BR_LSB 12
`define MFR_FLT_BR_MSB 14

// ==========================================================================
// pin input vector positions
`define MFR_PIN_W 10
`define MFR_PIN_ILIM 0
`define MFR_PIN_UP 1
`define MFR_PIN_DN 2
`define MFR_PIN_EARLY 3
`define MFR_PIN_BEMF 4
`define MFR_PIN_OTW_HOT 5
`define MFR_PIN_OTW_COOL 6
`define MFR_PIN_TSD_HOT 7
`define MFR_PIN_TSD_COOL 8
`define MFR_PIN_CPUV 9

// ==========================================================================
// timing
`define MFR_CLK_KHZ 100000
`define MFR_IPD_TMO_MS 500
`define MFR_IPD_CNT_W 26

`endif

// ===== hw/mfr_pkg.sv
package mfr_pkg;

    typedef enum logic [2:0] {
        MFR_BR_HIZ = 3'b000,
        MFR_BR_RECIRC = 3'b001,
        MFR_BR_HS_BRAKE = 3'b010,
        MFR_BR_LS_BRAKE = 3'b011,
        MFR_BR_ACTIVE = 3'b100
    } mfr_bridge_t;

    typedef enum logic [1:0] {
        MFR_LK_IDLE = 2'b00,
        MFR_LK_LATCH = 2'b01,
        MFR_LK_RETRY = 2'b10,
        MFR_LK_REPORT = 2'b11
    } mfr_lock_st_t;

    typedef enum logic [1:0] {
        MFR_ACT_LATCH = 2'b00,
        MFR_ACT_RETRY = 2'b01,
        MFR_ACT_REPORT = 2'b10,
        MFR_ACT_IGNORE = 2'b11
    } mfr_lock_act_t;

    // low bit set with top bit set means ignore; other top-bit codes report
    function automatic mfr_lock_act_t mfr_lock_act(input logic [3:0] sel);
        if (!sel[3]) begin
            mfr_lock_act = sel[2] ? MFR_ACT_RETRY : MFR_ACT_LATCH;
        end else begin
            mfr_lock_act = sel[0] ? MFR_ACT_IGNORE : MFR_ACT_REPORT;
        end
    endfunction

endpackage

// ===== hw/mfr_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module mfr_sync3 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a bit moves only once the last two stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    q[i] <= s3_r[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/mfr_fault_top.sv
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "mfr_regs.svh"
module mfr_fault_top #(
    parameter int IPD_TMO_CYC = `MFR_IPD_TMO_MS * `MFR_CLK_KHZ
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`MFR_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    input wire logic ILIM_OVER,
    input wire logic IPD_RAMPUP_ACT,
    input wire logic IPD_RAMPDN_ACT,
    input wire logic IPD_PULSE_EARLY,
    input wire logic BEMF_BELOW_THR,
    input wire logic OTW_HOT,
    input wire logic OTW_COOL,
    input wire logic TSD_HOT,
    input wire logic TSD_COOL,
    input wire logic CHARGE_PUMP_UV,
    input wire logic ANALOG_SUPPLY_UNDERVOLTAGE,
    input wire logic BUCK_UNDERVOLTAGE,
    output logic FAULT_OUT_N,
    output var mfr_pkg::mfr_bridge_t BRIDGE_STATE,
    output logic CHARGE_PUMP_EN,
    output logic CONTROLLER_EN,
    output logic BUCK_HS_EN,
    output logic BUCK_LS_EN
);
    import mfr_pkg::*;

    // ======================================================================
    // reset
    logic rst_a_n;
    logic rst_s1_r;
    logic rst_n;

    assign rst_a_n = NRST & ~ANALOG_SUPPLY_UNDERVOLTAGE & ~BUCK_UNDERVOLTAGE;

    always_ff @(posedge CLK or negedge rst_a_n) begin
        if (!rst_a_n) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // buck FETs off
    // straight from the comparator: the buck must stop without a clock
    assign BUCK_HS_EN = ~BUCK_UNDERVOLTAGE;
    assign BUCK_LS_EN = ~BUCK_UNDERVOLTAGE;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            CHARGE_PUMP_EN <= 1'b0;
            CONTROLLER_EN <= 1'b0;
        end else begin
            CHARGE_PUMP_EN <= 1'b1;
            CONTROLLER_EN <= 1'b1;
        end
    end

    // ======================================================================
    // pin synchronisers
    logic [`MFR_PIN_W-1:0] pin_s;

    mfr_sync3 #(.W(`MFR_PIN_W)) u_sync (
        .clk(CLK),
        .rst_n(rst_n),
        .d({CHARGE_PUMP_UV, TSD_COOL, TSD_HOT, OTW_COOL, OTW_HOT,
            BEMF_BELOW_THR, IPD_PULSE_EARLY, IPD_RAMPDN_ACT,
            IPD_RAMPUP_ACT, ILIM_OVER}),
        .q(pin_s)
    );

    // ======================================================================
    // register bus
    logic [3:0] sel_r;
    logic tmo_en_r;
    logic thermal_warning_report_en_r;
    logic meas_r;
    logic res_r;
    logic ind_r;
    logic ke_r;
    logic clr_r;
    logic [`MFR_RETRY_W-1:0] retry_r;
    logic [`MFR_EV_W-1:0] sts_r;
    logic [`MFR_EV_W-1:0] msk_r;
    logic [`MFR_EV_W-1:0] fl_r;
    logic [`MFR_EV_W-1:0] fl_prev_r;
    logic ctrl_flt;
    logic drv_flt;
    logic hit;
    logic acc;
    logic wr;
    logic [31:0] rd_mux;

    assign acc = PSEL & PENABLE;
    assign hit = (PADDR == `MFR_CTRL_OFS) || (PADDR == `MFR_RETRY_OFS) ||
                 (PADDR == `MFR_IRQ_STS_OFS) || (PADDR == `MFR_IRQ_MSK_OFS) ||
                 (PADDR == `MFR_FLT_OFS);
    assign wr = acc & PWRITE & hit;
    assign PREADY = 1'b1;
    assign PSLVERR = acc & ~hit;

    always_comb begin
        rd_mux = '0;
        unique case (PADDR)
            `MFR_CTRL_OFS: begin
                rd_mux[`MFR_CTRL_SEL_MSB:`MFR_CTRL_SEL_LSB] = sel_r;
                rd_mux[`MFR_CTRL_TMO_EN] = tmo_en_r;
                rd_mux[`MFR_CTRL_THERMAL_WARNING_REPORT_EN] = thermal_warning_report_en_r;
                rd_mux[`MFR_CTRL_MEAS] = meas_r;
                rd_mux[`MFR_CTRL_RES] = res_r;
                rd_mux[`MFR_CTRL_IND] = ind_r;
                rd_mux[`MFR_CTRL_KE] = ke_r;
            end
            `MFR_RETRY_OFS: rd_mux[`MFR_RETRY_W-1:0] = retry_r;
            `MFR_IRQ_STS_OFS: rd_mux[`MFR_EV_W-1:0] = sts_r;
            `MFR_IRQ_MSK_OFS: rd_mux[`MFR_EV_W-1:0] = msk_r;
            `MFR_FLT_OFS: begin
                rd_mux[`MFR_EV_W-1:0] = fl_r;
                rd_mux[`MFR_FLT_CTRL] = ctrl_flt;
                rd_mux[`MFR_FLT_DRV] = drv_flt;
                rd_mux[`MFR_FLT_BR_MSB:`MFR_FLT_BR_LSB] = BRIDGE_STATE;
            end
            default: rd_mux = '0;
        endcase
    end

    // read data captured in setup so it stands through the access phase
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA <= '0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= rd_mux;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sel_r <= `MFR_SEL_RST;
            tmo_en_r <= 1'b0;
            thermal_warning_report_en_r <= 1'b0;
            meas_r <= 1'b0;
            res_r <= 1'b0;
            ind_r <= 1'b0;
            ke_r <= 1'b0;
            retry_r <= `MFR_RETRY_RST;
            msk_r <= '0;
        end else if (wr) begin
            if (PADDR == `MFR_CTRL_OFS) begin
                sel_r <= PWDATA[`MFR_CTRL_SEL_MSB:`MFR_CTRL_SEL_LSB];
                tmo_en_r <= PWDATA[`MFR_CTRL_TMO_EN];
                thermal_warning_report_en_r <= PWDATA[`MFR_CTRL_THERMAL_WARNING_REPORT_EN];
                meas_r <= PWDATA[`MFR_CTRL_MEAS];
                res_r <= PWDATA[`MFR_CTRL_RES];
                ind_r <= PWDATA[`MFR_CTRL_IND];
                ke_r <= PWDATA[`MFR_CTRL_KE];
            end
            if (PADDR == `MFR_RETRY_OFS) begin
                retry_r <= PWDATA[`MFR_RETRY_W-1:0];
            end
            if (PADDR == `MFR_IRQ_MSK_OFS) begin
                msk_r <= PWDATA[`MFR_EV_W-1:0];
            end
        end
    end

    // clear command is a one-cycle pulse
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            clr_r <= 1'b0;
        end else begin
            clr_r <= wr && (PADDR == `MFR_CTRL_OFS) && PWDATA[`MFR_CTRL_CLR];
        end
    end

    // ======================================================================
    // position-detect ramp timer
    logic [`MFR_IPD_CNT_W-1:0] ipd_cnt_r;
    logic ramp_act;
    logic tmo_hit;

    assign ramp_act = pin_s[`MFR_PIN_UP] | pin_s[`MFR_PIN_DN];
    assign tmo_hit = ramp_act &&
        (ipd_cnt_r == `MFR_IPD_CNT_W'(IPD_TMO_CYC - 1));

    // saturates so a stuck ramp flags only once
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ipd_cnt_r <= '0;
        end else if (!ramp_act) begin
            ipd_cnt_r <= '0;
        end else if (ipd_cnt_r != `MFR_IPD_CNT_W'(IPD_TMO_CYC)) begin
            ipd_cnt_r <= ipd_cnt_r + 1'b1;
        end
    end

    // ======================================================================
    // software lock current limit
    mfr_lock_st_t lk_st_r;
    logic [1:0] brake_r;
    logic [`MFR_RETRY_W-1:0] rcnt_r;
    logic ilim;

    assign ilim = pin_s[`MFR_PIN_ILIM];

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            lk_st_r <= MFR_LK_IDLE;
        end else begin
            unique case (lk_st_r)
                MFR_LK_IDLE: begin
                    if (ilim) begin
                        unique case (mfr_lock_act(sel_r))
                            MFR_ACT_LATCH: lk_st_r <= MFR_LK_LATCH;
                            MFR_ACT_RETRY: lk_st_r <= MFR_LK_RETRY;
                            MFR_ACT_REPORT: lk_st_r <= MFR_LK_REPORT;
                            MFR_ACT_IGNORE: lk_st_r <= MFR_LK_IDLE;
                        endcase
                    end
                end
                MFR_LK_LATCH, MFR_LK_REPORT: begin
                    if (clr_r && !ilim) begin
                        lk_st_r <= MFR_LK_IDLE;
                    end
                end
                MFR_LK_RETRY: begin
                    if (rcnt_r == '0) begin
                        lk_st_r <= MFR_LK_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            brake_r <= 2'b00;
        end else if (lk_st_r == MFR_LK_IDLE && ilim) begin
            brake_r <= sel_r[1:0];
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_r <= '0;
        end else if (lk_st_r == MFR_LK_IDLE) begin
            rcnt_r <= retry_r;
        end else if (lk_st_r == MFR_LK_RETRY && rcnt_r != '0) begin
            rcnt_r <= rcnt_r - 1'b1;
        end
    end

    // ======================================================================
    // fault flags: set wins over clear
    logic [`MFR_EV_W-1:0] fl_set;
    logic [`MFR_EV_W-1:0] fl_clr;
    logic cpuv;

    assign cpuv = pin_s[`MFR_PIN_CPUV];

    always_comb begin
        fl_set = '0;
        fl_clr = '0;
        fl_set[`MFR_FL_RAMPUP] = tmo_en_r & tmo_hit & pin_s[`MFR_PIN_UP];
        fl_set[`MFR_FL_RAMPDN] = tmo_en_r & tmo_hit & pin_s[`MFR_PIN_DN];
        fl_set[`MFR_FL_RATE] = tmo_en_r & pin_s[`MFR_PIN_EARLY];
        fl_set[`MFR_FL_MPOS] = tmo_hit & (meas_r | res_r | ind_r);
        fl_set[`MFR_FL_MBEMF] = pin_s[`MFR_PIN_BEMF] & (meas_r | ke_r);
        fl_set[`MFR_FL_OTW] = pin_s[`MFR_PIN_OTW_HOT];
        fl_set[`MFR_FL_TSD] = pin_s[`MFR_PIN_TSD_HOT];
        fl_set[`MFR_FL_CPUV] = cpuv;
        fl_clr = {`MFR_EV_W{clr_r}};
        fl_clr[`MFR_FL_OTW] = clr_r & pin_s[`MFR_PIN_OTW_COOL];
        fl_clr[`MFR_FL_TSD] = clr_r & pin_s[`MFR_PIN_TSD_COOL];
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            fl_r <= '0;
        end else begin
            fl_r <= (fl_r & ~fl_clr) | fl_set;
            fl_r[`MFR_FL_LOCK] <= (lk_st_r != MFR_LK_IDLE);
        end
    end

    // ======================================================================
    // bridge and fault pin
    logic hiz;

    assign hiz = fl_r[`MFR_FL_RAMPUP] | fl_r[`MFR_FL_RAMPDN] |
                 fl_r[`MFR_FL_RATE] | fl_r[`MFR_FL_MPOS] |
                 fl_r[`MFR_FL_MBEMF] | fl_r[`MFR_FL_TSD] | cpuv;
    // warning reaches pin only if enabled
    assign ctrl_flt = (|fl_r[`MFR_FL_MBEMF:`MFR_FL_LOCK]) |
                      fl_r[`MFR_FL_TSD] | (fl_r[`MFR_FL_OTW] & thermal_warning_report_en_r);
    // driver fault follows live pump level
    assign drv_flt = cpuv;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            BRIDGE_STATE <= MFR_BR_HIZ;
        end else if (hiz) begin
            BRIDGE_STATE <= MFR_BR_HIZ;
        end else if (lk_st_r == MFR_LK_LATCH || lk_st_r == MFR_LK_RETRY) begin
            BRIDGE_STATE <= mfr_bridge_t'({1'b0, brake_r});
        end else begin
            BRIDGE_STATE <= MFR_BR_ACTIVE;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            FAULT_OUT_N <= 1'b1;
        end else begin
            FAULT_OUT_N <= ~(ctrl_flt | drv_flt);
        end
    end

    // ======================================================================
    // interrupts: rising flags, cleared by reading, set wins
    logic rd_sts;

    assign rd_sts = acc & ~PWRITE & (PADDR == `MFR_IRQ_STS_OFS);

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            fl_prev_r <= '0;
            sts_r <= '0;
            IRQ <= 1'b0;
        end else begin
            fl_prev_r <= fl_r;
            sts_r <= (sts_r & ~(rd_sts ? PRDATA[`MFR_EV_W-1:0] : '0)) |
                     (fl_r & ~fl_prev_r);
            IRQ <= |(sts_r & msk_r);
        end
    end

    // ======================================================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    sequence s_hiz_pin;
        BRIDGE_STATE == MFR_BR_HIZ && !FAULT_OUT_N;
    endsequence

    property p_lock_hold;
        lk_st_r == MFR_LK_LATCH && !clr_r |=> lk_st_r == MFR_LK_LATCH;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("latched lock left without clear");

    property p_brake;
        lk_st_r == MFR_LK_LATCH && !hiz |=>
            BRIDGE_STATE == mfr_bridge_t'({1'b0, $past(brake_r)});
    endproperty
    a_brake: assert property (p_brake)
        else $error("bridge does not match selected brake");

    property p_rampup;
        fl_set[`MFR_FL_RAMPUP] |=> fl_r[`MFR_FL_RAMPUP] ##1 s_hiz_pin;
    endproperty
    a_rampup: assert property (p_rampup)
        else $error("ramp timeout not acted on");

    property p_rate;
        tmo_en_r && pin_s[`MFR_PIN_EARLY] |=> fl_r[`MFR_FL_RATE] ##1 s_hiz_pin;
    endproperty
    a_rate: assert property (p_rate)
        else $error("early pulse not acted on");

    property p_mpos;
        tmo_hit && res_r |=> fl_r[`MFR_FL_MPOS] ##1 s_hiz_pin;
    endproperty
    a_mpos: assert property (p_mpos)
        else $error("measurement fault not acted on");

    property p_otw_quiet;
        fl_r == (`MFR_EV_W'(1) << `MFR_FL_OTW) && !thermal_warning_report_en_r && !cpuv
            |=> FAULT_OUT_N && BRIDGE_STATE == MFR_BR_ACTIVE;
    endproperty
    a_otw_quiet: assert property (p_otw_quiet)
        else $error("unreported warning disturbed pin or bridge");

    property p_tsd;
        pin_s[`MFR_PIN_TSD_HOT] |=> fl_r[`MFR_FL_TSD] ##1 s_hiz_pin;
    endproperty
    a_tsd: assert property (p_tsd)
        else $error("shutdown not acted on");

    property p_cpuv;
        // pin and bridge follow the live level, so only the next cycle is due
        cpuv |=> fl_r[`MFR_FL_CPUV] ##0 s_hiz_pin;
    endproperty
    a_cpuv: assert property (p_cpuv)
        else $error("pump undervoltage not acted on");

    property p_cpuv_sticky;
        fl_r[`MFR_FL_CPUV] && !clr_r |=> fl_r[`MFR_FL_CPUV];
    endproperty
    a_cpuv_sticky: assert property (p_cpuv_sticky)
        else $error("pump flag dropped without clear");

    property p_retry_load;
        $rose(lk_st_r == MFR_LK_RETRY) |-> rcnt_r == $past(retry_r);
    endproperty
    a_retry_load: assert property (p_retry_load)
        else $error("retry counter not loaded from setting");
endmodule
`default_nettype wire

// ===== testbench/mfr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module mfr_host_model (
    input wire logic clk,
    input wire logic fault_n,
    input wire logic ack,
    output logic seen
);
    // host latches any low level on the fault line until it acknowledges
    always_ff @(posedge clk) begin
        seen <= ack ? 1'b0 : (seen | ~fault_n);
    end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "mfr_regs.svh"
module testbench;
import mfr_pkg::*;
logic clk, nrst, psel, pen, pwr, pslverr, pready, irq, fault_n, err;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rd;
logic [9:0] pins;
logic analog_supply_undervoltage, buck_undervoltage, cp_en, ctl_en, bhs, bls, seen, ack;
mfr_bridge_t br;
int num_errors = 0;
int n_compared = 0;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    num_errors++; $display("BAD %0t got %0h want %0h", $time, (a), (b)); \
    end end
localparam logic [31:0] CLR = 32'h80000000;

mfr_fault_top #(.IPD_TMO_CYC(50)) uut (.CLK(clk), .NRST(nrst),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IRQ(irq), .ILIM_OVER(pins[`MFR_PIN_ILIM]),
    .IPD_RAMPUP_ACT(pins[`MFR_PIN_UP]), .IPD_RAMPDN_ACT(pins[`MFR_PIN_DN]),
    .IPD_PULSE_EARLY(pins[`MFR_PIN_EARLY]),
    .BEMF_BELOW_THR(pins[`MFR_PIN_BEMF]), .OTW_HOT(pins[`MFR_PIN_OTW_HOT]),
    .OTW_COOL(pins[`MFR_PIN_OTW_COOL]), .TSD_HOT(pins[`MFR_PIN_TSD_HOT]),
    .TSD_COOL(pins[`MFR_PIN_TSD_COOL]), .CHARGE_PUMP_UV(pins[`MFR_PIN_CPUV]),
    .ANALOG_SUPPLY_UNDERVOLTAGE(analog_supply_undervoltage), .BUCK_UNDERVOLTAGE(buck_undervoltage),
    .FAULT_OUT_N(fault_n), .BRIDGE_STATE(br), .CHARGE_PUMP_EN(cp_en),
    .CONTROLLER_EN(ctl_en), .BUCK_HS_EN(bhs), .BUCK_LS_EN(bls));
mfr_host_model host (.clk(clk), .fault_n(fault_n), .ack(ack), .seen(seen));

initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end

// ==========================================================================
// bus and check helpers
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // only the watchdog ends a wait for the slave
    do begin
        @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
endtask

task automatic look(input mfr_bridge_t eb, input logic en);
    `CHK(br, eb)
    `CHK(fault_n, en)
endtask

// kind 0 latched, 1 timed retry, 2 thermal (no check while cooling)
task automatic ev(input int idx, input logic [31:0] ctrl, input int hold,
                  input mfr_bridge_t eb, input logic en, input int kind);
    apb(1'b1, `MFR_CTRL_OFS, ctrl);
    pins[idx] <= 1'b1;
    repeat (hold) @(posedge clk);
    look(eb, en);
    pins[idx] <= 1'b0;
    pins[`MFR_PIN_OTW_COOL] <= 1'b1;
    pins[`MFR_PIN_TSD_COOL] <= 1'b1;
    repeat (10) @(posedge clk);
    if (kind != 2) look(eb, en);
    if (kind == 1) repeat (25) @(posedge clk);
    else apb(1'b1, `MFR_CTRL_OFS, ctrl | CLR);
    pins[`MFR_PIN_OTW_COOL] <= 1'b0;
    pins[`MFR_PIN_TSD_COOL] <= 1'b0;
    repeat (8) @(posedge clk);
    look(MFR_BR_ACTIVE, 1'b1);
endtask

// ==========================================================================
// scenarios
task automatic t_lock;
    mfr_bridge_t eb;
    logic en;
    apb(1'b1, `MFR_RETRY_OFS, 32'h00000014);
    for (int s = 0; s < 16; s++) begin
        eb = s[3] ? MFR_BR_ACTIVE : mfr_bridge_t'({1'b0, s[1:0]});
        en = s[3] & s[0];
        ev(`MFR_PIN_ILIM, s, 8, eb, en, (s[3:2] == 2'b01));
    end
endtask

task automatic t_other;
    ev(`MFR_PIN_UP, 32'h10, 65, MFR_BR_HIZ, 1'b0, 0);
    ev(`MFR_PIN_UP, 32'h10, 40, MFR_BR_ACTIVE, 1'b1, 0);
    ev(`MFR_PIN_UP, 32'h00, 65, MFR_BR_ACTIVE, 1'b1, 0);
    ev(`MFR_PIN_DN, 32'h10, 65, MFR_BR_HIZ, 1'b0, 0);
    ev(`MFR_PIN_EARLY, 32'h10, 8, MFR_BR_HIZ, 1'b0, 0);
    ev(`MFR_PIN_UP, 32'h100, 65, MFR_BR_HIZ, 1'b0, 0);
    ev(`MFR_PIN_UP, 32'h80, 65, MFR_BR_HIZ, 1'b0, 0);
    ev(`MFR_PIN_BEMF, 32'h200, 8, MFR_BR_HIZ, 1'b0, 0);
    ev(`MFR_PIN_BEMF, 32'h40, 8, MFR_BR_HIZ, 1'b0, 0);
    ev(`MFR_PIN_BEMF, 32'h180, 8, MFR_BR_ACTIVE, 1'b1, 0);
    ev(`MFR_PIN_OTW_HOT, 32'h20, 8, MFR_BR_ACTIVE, 1'b0, 2);
    ev(`MFR_PIN_OTW_HOT, 32'h00, 8, MFR_BR_ACTIVE, 1'b1, 2);
    ev(`MFR_PIN_TSD_HOT, 32'h00, 8, MFR_BR_HIZ, 1'b0, 2);
endtask

task automatic t_irq;
    apb(1'b0, `MFR_IRQ_STS_OFS, 32'h0);
    apb(1'b1, `MFR_IRQ_MSK_OFS, 32'h0);
    pins[`MFR_PIN_TSD_HOT] <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(irq, 1'b0)
    apb(1'b1, `MFR_IRQ_MSK_OFS, 32'h1 << `MFR_FL_TSD);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1'b0, `MFR_IRQ_STS_OFS, 32'h0);
    `CHK(rd[`MFR_FL_TSD], 1'b1)
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    pins[`MFR_PIN_TSD_HOT] <= 1'b0;
    pins[`MFR_PIN_TSD_COOL] <= 1'b1;
    // clear only counts once the cool level is through the synchroniser
    repeat (6) @(posedge clk);
    apb(1'b1, `MFR_CTRL_OFS, CLR);
    pins[`MFR_PIN_TSD_COOL] <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(br, MFR_BR_ACTIVE)
endtask

task automatic t_pump;
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    pins[`MFR_PIN_CPUV] <= 1'b1;
    repeat (8) @(posedge clk);
    look(MFR_BR_HIZ, 1'b0);
    apb(1'b0, `MFR_FLT_OFS, 32'h0);
    `CHK({rd[`MFR_FLT_DRV], rd[`MFR_FL_CPUV]}, 2'b11)
    pins[`MFR_PIN_CPUV] <= 1'b0;
    repeat (8) @(posedge clk);
    look(MFR_BR_ACTIVE, 1'b1);
    `CHK(seen, 1'b1)
    apb(1'b0, `MFR_FLT_OFS, 32'h0);
    `CHK({rd[`MFR_FLT_DRV], rd[`MFR_FL_CPUV]}, 2'b01)
    apb(1'b1, `MFR_CTRL_OFS, CLR);
    apb(1'b0, `MFR_FLT_OFS, 32'h0);
    `CHK(rd[`MFR_FL_CPUV], 1'b0)
endtask

task automatic t_supply;
    apb(1'b0, 12'h020, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, `MFR_RETRY_OFS, 32'h00000030);
    analog_supply_undervoltage <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK({ctl_en, cp_en}, 2'b00)
    `CHK(br, MFR_BR_HIZ)
    analog_supply_undervoltage <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(ctl_en, 1'b1)
    apb(1'b0, `MFR_RETRY_OFS, 32'h0);
    `CHK(rd, {8'h00, `MFR_RETRY_RST})
    buck_undervoltage <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK({bhs, bls}, 2'b00)
    `CHK(ctl_en, 1'b0)
    buck_undervoltage <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK({bhs, bls, ctl_en}, 3'b111)
endtask

// ==========================================================================
// run control
task automatic report_and_stop;
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask

initial begin
    #300us;
    num_errors++;
    report_and_stop();
end

initial begin
    nrst = 1'b0;
    {psel, pen, pwr, ack, analog_supply_undervoltage, buck_undervoltage} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pins = 10'h000;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    t_lock();
    t_other();
    t_irq();
    t_pump();
    t_supply();
    report_and_stop();
end
endmodule
`default_nettype wire
